//--- relay_scan_consts.vh
// Register offsets, field positions, reset values and counts for the
// relay scan / input monitor block. Assumes a byte-addressed 32-bit bus.
`ifndef RELAY_SCAN_CONSTS_VH
`define RELAY_SCAN_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CLOSE     8'h00
`define OFS_OPEN      8'h04
`define OFS_STATE     8'h08
`define OFS_LIST_IDX  8'h0c
`define OFS_LIST_DATA 8'h10
`define OFS_LIST_LEN  8'h14
`define OFS_CTRL      8'h18
`define OFS_QCOND     8'h1c
`define OFS_QEVENT    8'h20
`define OFS_QENABLE   8'h24
`define OFS_QPTR      8'h28
`define OFS_QNTR      8'h2c
`define OFS_STB       8'h30
`define OFS_CFG_LOAD  8'h34
`define OFS_BUS_ADDR  8'h38
`define OFS_SCAN_STAT 8'h3c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_CONT_BIT 0
`define CTRL_INIT_BIT 1
`define CTRL_TRG_BIT  2
`define CTRL_SAVE_BIT 3
`define STB_QSUM_BIT  3

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_CONT     1'b0
`define RST_QPTR     8'hff
`define RST_QNTR     8'hff
`define RST_QENABLE  8'h00
`define RST_BUS_ADDR 5'h00
`define SAVE_SETUP_0 4'h0
`define MAX_STEPS    6'h20

`endif

//--- scan_list_mem.v
// Scan list storage: one word of output bits per scan position.
// Assumes one write port and one read port, read data one cycle late.
`default_nettype none

module scan_list_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // scan_list_mem

`default_nettype wire

//--- input_monitor.v
// Input sampling, transition filter and sticky event bits.
// Assumes raw inputs are asynchronous pins; masks come from core_clk logic.
`default_nettype none

module input_monitor #(
    parameter N = 8
) (
    input wire core_clk,
    input wire rst_b,
    input wire [N-1:0] din_pin,
    input wire [N-1:0] ptr_mask,
    input wire [N-1:0] ntr_mask,
    input wire event_clear,
    output wire [N-1:0] cond_level,
    output wire [N-1:0] event_bits
);

    // ----------------------------------------------------------------
    // Per-input synchroniser, edge filter and event latch
    // ----------------------------------------------------------------
    // Edges are ignored until the synchroniser holds real pin samples:
    // pulled-up inputs would otherwise fake a rising edge after reset
    reg [2:0] warm_q;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            warm_q <= 3'h0;
        end else begin
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end

    // Sampling every core clock is far above the minimum input rate
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            reg prev_q;
            reg evt_q;
            wire rise;
            wire fall;
            assign rise = sync_q & ~prev_q & warm_q[2];
            assign fall = ~sync_q & prev_q & warm_q[2];
            always @(posedge core_clk) begin
                if (!rst_b) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                    evt_q <= 1'b0;
                end else begin
                    meta_q <= din_pin[i];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                    // Set wins over a read clear in the same cycle
                    if ((rise & ptr_mask[i]) | (fall & ntr_mask[i])) begin
                        evt_q <= 1'b1;
                    end else if (event_clear) begin
                        evt_q <= 1'b0;
                    end
                end
            end
            assign cond_level[i] = sync_q;
            assign event_bits[i] = evt_q;
        end
    endgenerate

endmodule // input_monitor

`default_nettype wire

//--- relay_scan_input_monitor.v
// Relay output latches, break-before-make scanner and input status.
// Assumes a command decoder drives the plain register port, with long and
// short command forms already reduced to the same register accesses.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`include "relay_scan_consts.vh"
`default_nettype none

module relay_scan_input_monitor #(
    parameter NOUT = 16,
    parameter NIN = 8,
    parameter STEPS = 32,
    parameter SW = 5
) (
    input wire core_clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire bus_trigger,
    input wire [NIN-1:0] din_pin,
    output reg [NOUT-1:0] relay_out,
    output reg relay_enable,
    output reg srq_pulse,
    output reg nv_save_valid,
    output reg [SW-1:0] nv_save_addr,
    output reg [NOUT-1:0] nv_save_data,
    output wire [5:0] nv_save_len
);

    // ----------------------------------------------------------------
    // Scanner states
    // ----------------------------------------------------------------
    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_LOAD = 2'b01;
    localparam [1:0] S_RUN = 2'b10;
    localparam [1:0] S_MAKE = 2'b11;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Long and short command forms arrive as the same strobes here
    wire wr_close = reg_wr && (reg_addr == `OFS_CLOSE);
    wire wr_open = reg_wr && (reg_addr == `OFS_OPEN);
    wire wr_idx = reg_wr && (reg_addr == `OFS_LIST_IDX);
    wire wr_data = reg_wr && (reg_addr == `OFS_LIST_DATA);
    wire wr_len = reg_wr && (reg_addr == `OFS_LIST_LEN);
    wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
    wire wr_qen = reg_wr && (reg_addr == `OFS_QENABLE);
    wire wr_ptr = reg_wr && (reg_addr == `OFS_QPTR);
    wire wr_ntr = reg_wr && (reg_addr == `OFS_QNTR);
    wire wr_load = reg_wr && (reg_addr == `OFS_CFG_LOAD);
    wire wr_baddr = reg_wr && (reg_addr == `OFS_BUS_ADDR);
    wire rd_event = reg_rd && (reg_addr == `OFS_QEVENT);

    wire init_cmd = wr_ctrl && reg_wdata[`CTRL_INIT_BIT];
    wire trg_cmd = wr_ctrl && reg_wdata[`CTRL_TRG_BIT];
    wire save_cmd = wr_ctrl && reg_wdata[`CTRL_SAVE_BIT]
                    && (reg_wdata[7:4] == `SAVE_SETUP_0);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [NOUT-1:0] latch_q;
    reg [NOUT-1:0] latch_d;
    reg out_en_q;
    reg cont_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [SW-1:0] pos_q;
    reg [SW-1:0] nxt_q;
    reg [NOUT-1:0] cur_q;
    reg [SW-1:0] idx_q;
    reg [5:0] len_q;
    reg [NIN-1:0] qen_q;
    reg [NIN-1:0] ptr_q;
    reg [NIN-1:0] ntr_q;
    reg [4:0] baddr_q;
    reg sum_q;
    reg save_busy_q;
    reg [SW-1:0] save_idx_q;
    reg save_rd_q;
    reg [SW-1:0] save_rd_addr_q;

    wire [NOUT-1:0] mem_rdata;
    wire [NIN-1:0] cond_level;
    wire [NIN-1:0] event_bits;

    assign nv_save_len = len_q;

    // ----------------------------------------------------------------
    // Scan list storage
    // ----------------------------------------------------------------
    wire last_pos = (({1'b0, pos_q} + 6'h01) == len_q);
    wire [SW-1:0] next_pos = last_pos ? {SW{1'b0}} : pos_q + 1'b1;
    reg [SW-1:0] mem_raddr;

    always @* begin
        if (save_busy_q) begin
            mem_raddr = save_idx_q;
        end else if (state_q == S_RUN) begin
            // A restart from a running scan must fetch position zero
            mem_raddr = init_cmd ? {SW{1'b0}} : next_pos;
        end else begin
            mem_raddr = {SW{1'b0}};
        end
    end

    scan_list_mem #(
        .WIDTH(NOUT),
        .DEPTH(STEPS),
        .AW(SW)
    ) u_list (
        .core_clk(core_clk),
        .wr_en(wr_data),
        .wr_addr(idx_q),
        .wr_data(reg_wdata[NOUT-1:0]),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    // ----------------------------------------------------------------
    // Scanner sequencing
    // ----------------------------------------------------------------
    // Triggers and initiate are held off while a save walks the list,
    // since both need the single read port.
    wire trig = (bus_trigger || trg_cmd) && !save_busy_q;
    wire list_ok = (len_q != 6'h00);
    wire init_go = init_cmd && list_ok && !save_busy_q
                   && (state_q != S_MAKE) && (state_q != S_LOAD);
    wire step_go = (state_q == S_RUN) && trig && cont_q && list_ok
                   && !init_go;
    reg scan_open;
    reg scan_close;

    always @* begin
        state_d = state_q;
        scan_open = 1'b0;
        scan_close = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (init_go) begin
                    state_d = S_LOAD;
                end
            end
            S_LOAD: begin
                scan_close = 1'b1;
                state_d = S_RUN;
            end
            S_RUN: begin
                if (init_go) begin
                    scan_open = 1'b1;
                    state_d = S_LOAD;
                end else if (step_go) begin
                    scan_open = 1'b1;
                    state_d = S_MAKE;
                end
            end
            S_MAKE: begin
                // Close one cycle after the break, using the word just read
                scan_close = 1'b1;
                state_d = S_RUN;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Output latch merge
    // ----------------------------------------------------------------
    always @* begin
        latch_d = latch_q;
        if (scan_open) begin
            latch_d = latch_d & ~cur_q;
        end
        if (scan_close) begin
            latch_d = latch_d | mem_rdata;
        end
        // Open and close commands touch only the named bits, so outputs outside
        // the scan list stay free to use while scanning
        if (wr_open) begin
            latch_d = latch_d & ~reg_wdata[NOUT-1:0];
        end
        if (wr_close) begin
            latch_d = latch_d | reg_wdata[NOUT-1:0];
        end
        if (wr_load) begin
            latch_d = reg_wdata[NOUT-1:0];
        end
    end

    wire out_en_d = out_en_q | wr_load;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            latch_q <= {NOUT{1'b0}};
            out_en_q <= 1'b0;
            relay_out <= {NOUT{1'b0}};
            relay_enable <= 1'b0;
        end else begin
            latch_q <= latch_d;
            out_en_q <= out_en_d;
            // Held off until the saved setup reaches the latches
            relay_out <= out_en_d ? latch_d : {NOUT{1'b0}};
            relay_enable <= out_en_d;
        end
    end

    // ----------------------------------------------------------------
    // Scanner and configuration registers
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            pos_q <= {SW{1'b0}};
            nxt_q <= {SW{1'b0}};
            cur_q <= {NOUT{1'b0}};
            cont_q <= `RST_CONT;
            idx_q <= {SW{1'b0}};
            len_q <= 6'h00;
            qen_q <= `RST_QENABLE;
            ptr_q <= `RST_QPTR;
            ntr_q <= `RST_QNTR;
            baddr_q <= `RST_BUS_ADDR;
        end else begin
            state_q <= state_d;
            if (step_go && (state_q == S_RUN)) begin
                nxt_q <= next_pos;
            end
            if (state_q == S_LOAD) begin
                pos_q <= {SW{1'b0}};
                cur_q <= mem_rdata;
            end else if (state_q == S_MAKE) begin
                pos_q <= nxt_q;
                cur_q <= mem_rdata;
            end else if (scan_open) begin
                cur_q <= {NOUT{1'b0}};
            end
            if (wr_ctrl) begin
                // Initiate also turns the scanner on
                cont_q <= reg_wdata[`CTRL_CONT_BIT] | init_cmd;
            end
            if (wr_idx) begin
                idx_q <= reg_wdata[SW-1:0];
            end else if (wr_data) begin
                idx_q <= idx_q + 1'b1;
            end
            if (wr_len) begin
                // Longer lists are clipped to the storage depth
                len_q <= (reg_wdata[5:0] > `MAX_STEPS) ? `MAX_STEPS : reg_wdata[5:0];
            end
            if (wr_qen) begin
                qen_q <= reg_wdata[NIN-1:0];
            end
            if (wr_ptr) begin
                ptr_q <= reg_wdata[NIN-1:0];
            end
            if (wr_ntr) begin
                ntr_q <= reg_wdata[NIN-1:0];
            end
            if (wr_baddr) begin
                baddr_q <= reg_wdata[4:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Save of the scan list to nonvolatile storage
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            save_busy_q <= 1'b0;
            save_idx_q <= {SW{1'b0}};
            save_rd_q <= 1'b0;
            save_rd_addr_q <= {SW{1'b0}};
            nv_save_valid <= 1'b0;
            nv_save_addr <= {SW{1'b0}};
            nv_save_data <= {NOUT{1'b0}};
        end else begin
            save_rd_q <= save_busy_q;
            save_rd_addr_q <= save_idx_q;
            nv_save_valid <= save_rd_q;
            if (save_rd_q) begin
                nv_save_addr <= save_rd_addr_q;
                nv_save_data <= mem_rdata;
            end
            if (save_busy_q) begin
                save_idx_q <= save_idx_q + 1'b1;
                if (save_idx_q == STEPS - 1) begin
                    save_busy_q <= 1'b0;
                end
            end else if (save_cmd && state_q != S_LOAD && state_q != S_MAKE) begin
                save_busy_q <= 1'b1;
                save_idx_q <= {SW{1'b0}};
            end
        end
    end

    // ----------------------------------------------------------------
    // Input status
    // ----------------------------------------------------------------
    input_monitor #(
        .N(NIN)
    ) u_mon (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .din_pin(din_pin),
        .ptr_mask(ptr_q),
        .ntr_mask(ntr_q),
        .event_clear(rd_event),
        .cond_level(cond_level),
        .event_bits(event_bits)
    );

    wire sum_d = |(event_bits & qen_q);

    always @(posedge core_clk) begin
        if (!rst_b) begin
            sum_q <= 1'b0;
            srq_pulse <= 1'b0;
        end else begin
            sum_q <= sum_d;
            srq_pulse <= sum_d & ~sum_q;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_STATE: reg_rdata <= {16'h0000, latch_q};
                `OFS_LIST_IDX: reg_rdata <= {27'h0, idx_q};
                `OFS_LIST_LEN: reg_rdata <= {26'h0, len_q};
                `OFS_CTRL: reg_rdata <= {31'h0, cont_q};
                `OFS_QCOND: reg_rdata <= {24'h000000, cond_level};
                `OFS_QEVENT: reg_rdata <= {24'h000000, event_bits};
                `OFS_QENABLE: reg_rdata <= {24'h000000, qen_q};
                `OFS_QPTR: reg_rdata <= {24'h000000, ptr_q};
                `OFS_QNTR: reg_rdata <= {24'h000000, ntr_q};
                `OFS_STB: reg_rdata <= {28'h0000000, sum_q, 3'h0};
                `OFS_BUS_ADDR: reg_rdata <= {27'h0, baddr_q};
                `OFS_SCAN_STAT: reg_rdata <= {22'h0, save_busy_q, relay_enable,
                                              state_q, 1'b0, pos_q};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // relay_scan_input_monitor

`default_nettype wire

//--- bus_side_model.sv
// Far-side stand-in: trigger pulses from the bus engine and the input pins.
// Assumes the bench asks for at most one trigger every second cycle.
`default_nettype none

module bus_side_model (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [7:0] level,
    output logic bus_trigger,
    output logic [7:0] din_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_trigger = 1'b0;
        din_pin = 8'h00;
    end

    // One pulse per request, so each request is at most one step
    always @(posedge core_clk) begin
        bus_trigger <= fire;
        din_pin <= level;
    end
endmodule // bus_side_model

`default_nettype wire

//--- relay_scan_checker_properties.sv
// Port-level checks of the relay scan block.
// Assumes the constants header is on the include path; bound at the foot.
`include "relay_scan_consts.vh"
`default_nettype none

module relay_scan_checker #(
    parameter NOUT = 16,
    parameter NIN = 8,
    parameter SW = 5
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic bus_trigger,
    input wire logic [NIN-1:0] din_pin,
    input wire logic [NOUT-1:0] relay_out,
    input wire logic relay_enable,
    input wire logic srq_pulse,
    input wire logic nv_save_valid,
    input wire logic [SW-1:0] nv_save_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Delayed copies, since $past cannot be sliced
    logic [NOUT-1:0] wd_q;
    logic [SW-1:0] sa_q;
    always_ff @(posedge core_clk) begin
        wd_q <= reg_wdata[NOUT-1:0];
        sa_q <= nv_save_addr;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_cond_readback: assert property ($stable(din_pin) [*4] ##0
        (reg_rd && reg_addr == `OFS_QCOND) |=> reg_rdata == {{(32-NIN){1'b0}}, $past(din_pin)})
        else $error("condition read does not show input levels");
    a_held_off: assert property (!relay_enable |-> relay_out == '0)
        else $error("outputs driven before enable");
    a_enable_sticky: assert property (relay_enable |=> relay_enable)
        else $error("output enable dropped");
    a_load_enables: assert property ((reg_wr && reg_addr == `OFS_CFG_LOAD)
        |=> relay_enable && relay_out == wd_q)
        else $error("configuration load not applied");
    a_close_sets: assert property ((reg_wr && reg_addr == `OFS_CLOSE && relay_enable)
        |=> (relay_out & wd_q) == wd_q)
        else $error("close did not close named outputs");
    a_open_clears: assert property ((reg_wr && reg_addr == `OFS_OPEN && relay_enable)
        |=> (relay_out & wd_q) == '0)
        else $error("open did not open named outputs");
    a_break_make: assert property ((relay_enable && $past(relay_enable) && !$past(reg_wr)
        && !$past(reg_wr, 2)) |-> ((relay_out & ~$past(relay_out)) == '0)
        || ((~relay_out & $past(relay_out)) == '0))
        else $error("outputs opened and closed on the same edge");
    a_srq_single: assert property (srq_pulse |=> !srq_pulse)
        else $error("service request longer than one cycle");
    a_save_step: assert property ((nv_save_valid && nv_save_addr != {SW{1'b1}})
        |=> nv_save_valid && nv_save_addr == sa_q + 1'b1)
        else $error("save burst broke its address sequence");
    a_save_first: assert property ($rose(nv_save_valid) |-> nv_save_addr == '0)
        else $error("save burst did not start at position zero");

    c_srq: cover property (srq_pulse);
    c_save: cover property (nv_save_valid);
    c_enable: cover property ($rose(relay_enable));
    c_step: cover property (bus_trigger ##2 relay_out != '0);
endmodule // relay_scan_checker

bind relay_scan_input_monitor relay_scan_checker #(.NOUT(NOUT), .NIN(NIN), .SW(SW))
    u_relay_scan_checker (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_trigger(bus_trigger), .din_pin(din_pin), .relay_out(relay_out),
    .relay_enable(relay_enable), .srq_pulse(srq_pulse), .nv_save_valid(nv_save_valid),
    .nv_save_addr(nv_save_addr));

`default_nettype wire

//--- relay_scan_input_monitor_bench.sv
// Directed bench: register port tasks and scenario sequences.
// Assumes the constants header is reachable and the checker is bound.
`include "relay_scan_consts.vh"
`default_nettype none

module relay_scan_input_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fire = 1'b0;
    logic [7:0] din_level = 8'h00;
    wire logic [31:0] reg_rdata;
    wire logic bus_trigger;
    wire logic [7:0] din_pin;
    wire logic [15:0] relay_out;
    wire logic relay_enable;
    wire logic srq_pulse;
    wire logic nv_save_valid;
    wire logic [4:0] nv_save_addr;
    wire logic [15:0] nv_save_data;
    wire logic [5:0] nv_save_len;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_srq = 0;
    int n_save = 0;
    logic [15:0] saved [0:31];

    relay_scan_input_monitor u_relay_scan_input_monitor (.core_clk(core_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_trigger(bus_trigger), .din_pin(din_pin),
        .relay_out(relay_out), .relay_enable(relay_enable), .srq_pulse(srq_pulse),
        .nv_save_valid(nv_save_valid), .nv_save_addr(nv_save_addr),
        .nv_save_data(nv_save_data), .nv_save_len(nv_save_len));
    bus_side_model u_bus_side_model (.core_clk(core_clk), .fire(fire), .level(din_level),
        .bus_trigger(bus_trigger), .din_pin(din_pin));

    always #10 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Pulse counting and hang guard
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (srq_pulse === 1'b1) n_srq++;
        if (nv_save_valid === 1'b1) begin
            n_save++;
            saved[nv_save_addr] = nv_save_data;
        end
        if (cyc == 6000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic trig();
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        settle(4);
    endtask

    task automatic set_din(input logic [7:0] v);
        @(posedge core_clk);
        din_level <= v;
        settle(6);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        settle(1);
        chk({31'h0, relay_enable}, 32'h0);
        wr(`OFS_CLOSE, 32'hffff);
        settle(1);
        chk({16'h0, relay_out}, 32'h0);
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_QPTR, 32'hff);
        rd(`OFS_QNTR, 32'hff);
        rd(`OFS_QENABLE, 32'h0);
        rd(`OFS_LIST_LEN, 32'h0);
        rd(8'h40, 32'h0);
        rd(`OFS_CLOSE, 32'h0);
        wr(`OFS_CFG_LOAD, 32'h00a5);
        settle(1);
        chk({16'h0, relay_out}, 32'h00a5);
        chk({31'h0, relay_enable}, 32'h1);
        wr(`OFS_CLOSE, 32'h0300);
        wr(`OFS_OPEN, 32'h0021);
        rd(`OFS_STATE, 32'h0384);
        trig();
        chk({16'h0, relay_out}, 32'h0384);
        wr(`OFS_LIST_IDX, 32'h0);
        for (int i = 0; i < 3; i++) wr(`OFS_LIST_DATA, 32'h1000 << i);
        rd(`OFS_LIST_IDX, 32'h3);
        wr(`OFS_LIST_LEN, 32'h3);
        wr(`OFS_CTRL, 32'h2);
        settle(3);
        chk({16'h0, relay_out}, 32'h1384);
        rd(`OFS_CTRL, 32'h1);
        trig();
        chk({16'h0, relay_out}, 32'h2384);
        wr(`OFS_CTRL, 32'h5);
        settle(4);
        chk({16'h0, relay_out}, 32'h4384);
        trig();
        chk({16'h0, relay_out}, 32'h1384);
        trig();
        chk({16'h0, relay_out}, 32'h2384);
        rd(`OFS_SCAN_STAT, 32'h181);
        wr(`OFS_CTRL, 32'h2);
        settle(3);
        chk({16'h0, relay_out}, 32'h1384);
        rd(`OFS_SCAN_STAT, 32'h180);
        wr(`OFS_CLOSE, 32'h0001);
        settle(1);
        chk({16'h0, relay_out}, 32'h1385);
        wr(`OFS_CTRL, 32'h0);
        trig();
        chk({16'h0, relay_out}, 32'h1385);
        wr(`OFS_CTRL, 32'h18);
        settle(40);
        chk(n_save, 32'h0);
        wr(`OFS_CTRL, 32'h8);
        settle(40);
        chk(n_save, 32'h20);
        for (int i = 0; i < 3; i++) chk({16'h0, saved[i]}, 32'h1000 << i);
        chk({26'h0, nv_save_len}, 32'h3);
        wr(`OFS_QPTR, 32'h01);
        wr(`OFS_QNTR, 32'h02);
        wr(`OFS_QENABLE, 32'h01);
        set_din(8'h03);
        rd(`OFS_QCOND, 32'h03);
        rd(`OFS_STB, 32'h08);
        rd(`OFS_QEVENT, 32'h01);
        chk(n_srq, 32'h1);
        rd(`OFS_QEVENT, 32'h00);
        rd(`OFS_STB, 32'h00);
        set_din(8'h00);
        rd(`OFS_QEVENT, 32'h02);
        chk(n_srq, 32'h1);
        wr(`OFS_BUS_ADDR, 32'h13);
        rd(`OFS_BUS_ADDR, 32'h13);
        wr(`OFS_LIST_LEN, 32'h28);
        rd(`OFS_LIST_LEN, 32'h20);
        complete_run();
    end
endmodule // relay_scan_input_monitor_bench

`default_nettype wire
